// File: rtl/probe_capture_pkg.sv
// Constants, register map and field layout of the two-probe position capture unit.
// Assumes an APB master with 32-bit data and one register per aligned word.
//
// Behaviour
// RL1: Probe one low byte, two high; reserved zero
// RL2: Status bit 0 shows probe one enabled
// RL3: Status bit 1 set after probe one rising capture
// RL4: Status bit 2 set after probe one falling capture
// RL5: Status bit 8 shows probe two enabled
// RL6: Status bit 9 set after probe two rising capture
// RL7: Status bit 10 set after probe two falling capture
// RL8: Function bit 2/10 selects pin or internal trigger
// RL9: Select object picks zero-phase (0) or timing (1)
// RL10: Latch source picks feedback (0) or command (1)
// RL11: Zero-phase captures feedback, timing captures command
// RL12: Function word: probe one low byte, two high
// RL13: Mode bit 1 continuous, 0 first trigger only
// RL14: Capture stores position, sets flag; disable clears flags
package probe_capture_pkg;

    // Register indices; byte address is four times the index
    localparam logic [17:0] IDX_PROBE_FUNCTION      = 18'h060B8;
    localparam logic [17:0] IDX_PROBE_STATUS_WORD   = 18'h060B9;
    localparam logic [17:0] IDX_PROBE1_POS_RISE     = 18'h060BA;
    localparam logic [17:0] IDX_PROBE1_POS_FALL     = 18'h060BB;
    localparam logic [17:0] IDX_PROBE2_POS_RISE     = 18'h060BC;
    localparam logic [17:0] IDX_PROBE2_POS_FALL     = 18'h060BD;
    localparam logic [17:0] IDX_PROBE1_LATCH_SOURCE = 18'h044B0;
    localparam logic [17:0] IDX_PROBE2_LATCH_SOURCE = 18'h044B1;
    localparam logic [17:0] IDX_PROBE1_INT_TRIG_SEL = 18'h044B2;
    localparam logic [17:0] IDX_PROBE2_INT_TRIG_SEL = 18'h044B3;
    localparam logic [17:0] IDX_IRQ_STATUS          = 18'h04500;
    localparam logic [17:0] IDX_IRQ_MASK            = 18'h04501;

    // Field positions within one probe's byte of function and status words
    localparam int BYTE_W        = 8;
    localparam int FN_ENABLE     = 0;
    localparam int FN_CONTINUOUS = 1;
    localparam int FN_TRIG_SEL   = 2;
    localparam int FN_RISE_EN    = 4;
    localparam int FN_FALL_EN    = 5;
    localparam int ST_ENABLED    = 0;
    localparam int ST_RISE_DONE  = 1;
    localparam int ST_FALL_DONE  = 2;

    // Interrupt status layout: bit 2*probe is rising, 2*probe+1 falling
    localparam int IRQ_W = 4;

    // Reset values
    localparam logic [15:0] RST_FUNCTION = 16'h0000;
    localparam logic [7:0]  RST_SEL_BYTE = 8'h00;
    localparam logic [3:0]  RST_IRQ_MASK = 4'h0;

endpackage : probe_capture_pkg

// File: rtl/touch_probe_latch_status.sv
// Two-probe position capture unit with APB register access and a level interrupt.
// Trigger pins come from outside the clock domain and pass two flip-flops first;
// positions come from logic on the same clock and are used directly.
//
// Our own choice: the APB slave port.
module touch_probe_latch_status #(
    parameter int ADDR_W = 20,
    parameter int POS_W  = 32
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              probe1_external_latch_input,
    input  wire logic              probe2_external_latch_input,
    input  wire logic              zero_phase_output,
    input  wire logic              timing_output,
    input  wire logic [POS_W-1:0]  feedback_position,
    input  wire logic [POS_W-1:0]  command_position
);

    typedef struct packed {
        logic [15:0]                function_word;
        logic [1:0][7:0]            latch_source;
        logic [1:0][7:0]            int_trig_sel;
        logic [1:0][POS_W-1:0]      pos_rise;
        logic [1:0][POS_W-1:0]      pos_fall;
        logic [1:0]                 rise_done;
        logic [1:0]                 fall_done;
        logic [3:0]                 sync_a;
        logic [3:0]                 sync_b;
        logic [1:0]                 trig_prev;
        logic [3:0]                 irq_status;
        logic [3:0]                 irq_mask;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       slverr;
        logic                       irq_out;
    } state_t;

    state_t       r;
    state_t       next_r;
    logic [1:0]   rst_pipe;
    logic         rst_sync_n;

    // Reset released through two flops so every state flop leaves reset on one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // Byte-lane merge for writes; lanes with pstrb low keep their old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Whole next-state computation: synchronisers, capture, APB slave, interrupt
    always_comb begin
        logic [17:0]       idx;
        logic              wr_now;
        logic              mapped;
        logic [31:0]       rd;
        logic [1:0]        trig_now;
        logic [1:0]        use_cmd;
        logic [POS_W-1:0]  qty;
        logic [3:0]        events;
        logic [15:0]       status;
        logic [31:0]       tmp;
        logic              en;
        logic              cont;
        idx      = paddr[19:2];
        wr_now   = 1'b0;
        mapped   = 1'b0;
        rd       = 32'h0000_0000;
        trig_now = 2'h0;
        use_cmd  = 2'h0;
        qty      = '0;
        events   = 4'h0;
        status   = 16'h0000;
        tmp      = 32'h0000_0000;
        en       = 1'b0;
        cont     = 1'b0;
        next_r   = r;

        // Second flop reads the first only; logic below reads the second
        next_r.sync_a = {timing_output, zero_phase_output,
                         probe2_external_latch_input, probe1_external_latch_input};
        next_r.sync_b = r.sync_a;

        // Per-probe trigger choice, captured quantity and edge capture
        for (int p = 0; p < 2; p++) begin
            if (!r.function_word[p*8 + probe_capture_pkg::FN_TRIG_SEL]) begin  // RL8
                trig_now[p] = r.sync_b[p];
                use_cmd[p]  = r.latch_source[p][0];                          // RL10
            end else if (!r.int_trig_sel[p][0]) begin                        // RL9
                trig_now[p] = r.sync_b[2];
                use_cmd[p]  = 1'b0;                                          // RL11
            end else begin
                trig_now[p] = r.sync_b[3];
                use_cmd[p]  = 1'b1;                                          // RL11
            end
            qty  = use_cmd[p] ? command_position : feedback_position;
            en   = r.function_word[p*8 + probe_capture_pkg::FN_ENABLE];     // RL12
            cont = r.function_word[p*8 + probe_capture_pkg::FN_CONTINUOUS];
            next_r.trig_prev[p] = trig_now[p];
            if (!en) begin
                next_r.rise_done[p] = 1'b0;                                  // RL14
                next_r.fall_done[p] = 1'b0;                                  // RL14
            end else begin
                // First-trigger mode ignores edges once its flag is set
                if (trig_now[p] && !r.trig_prev[p]
                        && r.function_word[p*8 + probe_capture_pkg::FN_RISE_EN]
                        && (cont || !r.rise_done[p])) begin                  // RL13
                    next_r.pos_rise[p]  = qty;                               // RL14
                    next_r.rise_done[p] = 1'b1;                              // RL3 RL6
                    events[2*p]         = 1'b1;
                end
                if (!trig_now[p] && r.trig_prev[p]
                        && r.function_word[p*8 + probe_capture_pkg::FN_FALL_EN]
                        && (cont || !r.fall_done[p])) begin                  // RL13
                    next_r.pos_fall[p]  = qty;                               // RL14
                    next_r.fall_done[p] = 1'b1;                              // RL4 RL7
                    events[2*p+1]       = 1'b1;
                end
            end
        end

        // Status word; reserved bits stay zero
        status = {5'h00, r.fall_done[1], r.rise_done[1], r.function_word[8],
                  5'h00, r.fall_done[0], r.rise_done[0], r.function_word[0]}; // RL1 RL2 RL5

        // One wait state: pready rises in the second access cycle, write lands there
        // A misaligned or out-of-range address is refused and must never write
        wr_now       = psel && penable && r.ready && pwrite && paddr[1:0] == 2'h0
                       && (paddr >> 20) == '0;
        next_r.ready = psel && penable && !r.ready;

        // Address decode and read mux
        mapped = 1'b1;
        if (idx == probe_capture_pkg::IDX_PROBE_FUNCTION) begin
            rd = {16'h0000, r.function_word};
            if (wr_now) begin
                tmp = lane_merge(rd, pwdata, pstrb);
                next_r.function_word = tmp[15:0];                            // RL12
            end
        end else if (idx == probe_capture_pkg::IDX_PROBE_STATUS_WORD) begin
            rd = {16'h0000, status};                                         // RL1
        end else if (idx == probe_capture_pkg::IDX_PROBE1_POS_RISE) begin
            rd = 32'(r.pos_rise[0]);
        end else if (idx == probe_capture_pkg::IDX_PROBE1_POS_FALL) begin
            rd = 32'(r.pos_fall[0]);
        end else if (idx == probe_capture_pkg::IDX_PROBE2_POS_RISE) begin
            rd = 32'(r.pos_rise[1]);
        end else if (idx == probe_capture_pkg::IDX_PROBE2_POS_FALL) begin
            rd = 32'(r.pos_fall[1]);
        end else if (idx == probe_capture_pkg::IDX_PROBE1_LATCH_SOURCE) begin
            rd = {24'h000000, r.latch_source[0]};
            if (wr_now && pstrb[0]) begin
                next_r.latch_source[0] = pwdata[7:0];                        // RL10
            end
        end else if (idx == probe_capture_pkg::IDX_PROBE2_LATCH_SOURCE) begin
            rd = {24'h000000, r.latch_source[1]};
            if (wr_now && pstrb[0]) begin
                next_r.latch_source[1] = pwdata[7:0];                        // RL10
            end
        end else if (idx == probe_capture_pkg::IDX_PROBE1_INT_TRIG_SEL) begin
            rd = {24'h000000, r.int_trig_sel[0]};
            if (wr_now && pstrb[0]) begin
                next_r.int_trig_sel[0] = pwdata[7:0];                        // RL9
            end
        end else if (idx == probe_capture_pkg::IDX_PROBE2_INT_TRIG_SEL) begin
            rd = {24'h000000, r.int_trig_sel[1]};
            if (wr_now && pstrb[0]) begin
                next_r.int_trig_sel[1] = pwdata[7:0];                        // RL9
            end
        end else if (idx == probe_capture_pkg::IDX_IRQ_STATUS) begin
            rd = {28'h0000000, r.irq_status};
        end else if (idx == probe_capture_pkg::IDX_IRQ_MASK) begin
            rd = {28'h0000000, r.irq_mask};
            if (wr_now && pstrb[0]) begin
                next_r.irq_mask = pwdata[3:0];
            end
        end else begin
            mapped = 1'b0;
        end
        if (paddr[1:0] != 2'h0 || (paddr >> 20) != '0) begin
            mapped = 1'b0;
        end

        // Read data and error are registered with pready; unmapped reads return zero
        if (next_r.ready) begin
            next_r.rdata  = (mapped && !pwrite) ? rd : 32'h0000_0000;
            next_r.slverr = !mapped;
        end else begin
            next_r.rdata  = 32'h0000_0000;
            next_r.slverr = 1'b0;
        end

        // Sticky interrupt bits: write one to clear, a same-cycle event wins
        next_r.irq_status = r.irq_status;
        if (wr_now && mapped && pstrb[0] && idx == probe_capture_pkg::IDX_IRQ_STATUS) begin
            next_r.irq_status = r.irq_status & ~pwdata[3:0];
        end
        next_r.irq_status = next_r.irq_status | events;
        next_r.irq_out    = |(next_r.irq_status & next_r.irq_mask);
    end

    // State register; asynchronous reset loads constants only
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r               <= '0;
            r.function_word <= probe_capture_pkg::RST_FUNCTION;
            r.latch_source  <= {2{probe_capture_pkg::RST_SEL_BYTE}};         // RL10
            r.int_trig_sel  <= {2{probe_capture_pkg::RST_SEL_BYTE}};         // RL9
            r.irq_mask      <= probe_capture_pkg::RST_IRQ_MASK;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign prdata  = r.rdata;
    assign pready  = r.ready;
    assign pslverr = r.slverr;
    assign irq     = r.irq_out;

endmodule : touch_probe_latch_status

// File: verif/touch_probe_latch_status_properties.sv
// Checker of the probe capture unit: APB answer timing and status layout.
// Sees only the top module's ports; bound into the design by the line at the foot.
module probe_capture_checker #(
    parameter int ADDR_W = 20,
    parameter int POS_W  = 32
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              probe1_external_latch_input,
    input wire logic              probe2_external_latch_input,
    input wire logic              zero_phase_output,
    input wire logic              timing_output,
    input wire logic [POS_W-1:0]  feedback_position,
    input wire logic [POS_W-1:0]  command_position
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // A read of a mapped word finishing in this cycle, and its index
    wire              rd_ok = pready && !pwrite && !pslverr;
    wire logic [17:0] idx   = paddr[19:2];

    // Every access phase waits exactly once
    property p_ready_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_sel;
        pready |-> psel && penable;
    endproperty
    a_ready_sel: assert property (p_ready_sel) else $error("pready outside access phase");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
    property p_misalign;
        pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
    // Reserved status bits must never leak, whatever the probes do
    property p_status_rsvd;
        rd_ok && idx == probe_capture_pkg::IDX_PROBE_STATUS_WORD
            |-> prdata[31:11] == 21'h0 && prdata[7:3] == 5'h0;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bit set");
    property p_byte_regs;
        rd_ok && idx[17:2] == 16'h112C |-> prdata[31:8] == 24'h0;
    endproperty
    a_byte_regs: assert property (p_byte_regs) else $error("select byte upper bits set");
endmodule : probe_capture_checker

bind touch_probe_latch_status probe_capture_checker #(.ADDR_W(ADDR_W), .POS_W(POS_W)) u_chk (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .probe1_external_latch_input(probe1_external_latch_input),
    .probe2_external_latch_input(probe2_external_latch_input),
    .zero_phase_output(zero_phase_output), .timing_output(timing_output),
    .feedback_position(feedback_position), .command_position(command_position));

// File: verif/probe_trigger_source.sv
// Trigger pins and position sources facing the probe capture unit.
// Driven by bench tasks; pins 0..3 are probe one pin, probe two pin, zero-phase, timing.
module probe_trigger_source (
    input  wire logic  clock,
    output logic [3:0]  pins,
    output logic [31:0] fb_pos,
    output logic [31:0] cmd_pos
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pins    = 4'h0;
        fb_pos  = 32'h0;
        cmd_pos = 32'h0;
    end
    // Each level is held long enough for the sync stages and the edge detect
    task automatic set_pin(input int n, input logic v);
        @(posedge clock);
        pins[n] <= v;
        repeat (6) @(posedge clock);
    endtask : set_pin
    // Positions stay still around a capture so the latched value is known
    task automatic set_pos(input logic [31:0] f, input logic [31:0] c);
        @(posedge clock);
        fb_pos  <= f;
        cmd_pos <= c;
    endtask : set_pos
endmodule : probe_trigger_source

// File: verif/touch_probe_latch_status_tb.sv
// Self-checking bench of the probe capture unit, driven as an APB master.
// Assumes the trigger source model and the bound property checker.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module touch_probe_latch_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rst_n, psel, penable, pwrite, rerr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rdata, fb, cm;
    logic [3:0]  pstrb, pins;
    logic        pready, pslverr, irq;
    int          n_fail = 0;
    int          tests_run = 0;

    probe_trigger_source u_probe_trigger_source (.clock(clock), .pins(pins), .fb_pos(fb),
        .cmd_pos(cm));
    touch_probe_latch_status u_touch_probe_latch_status (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .probe1_external_latch_input(pins[0]), .probe2_external_latch_input(pins[1]),
        .zero_phase_output(pins[2]), .timing_output(pins[3]), .feedback_position(fb),
        .command_position(cm));

    always #2 clock = ~clock;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [17:0] idx, input logic [31:0] d,
                        input logic [1:0] lo = 2'h0);
        int i;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, lo};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            print_verdict();
        end
    endtask : xfer
    task automatic wr(input logic [17:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [17:0] idx, input string nm, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        `CHK(nm, exp, rdata)
    endtask : rd
    // Irq is registered on the same edge as the sticky bits and mask it comes from
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clock);
        `CHK("irq", exp, irq)
    endtask : chk_irq

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(probe_capture_pkg::IDX_PROBE1_LATCH_SOURCE, "src1", 32'h0);
        rd(probe_capture_pkg::IDX_PROBE2_LATCH_SOURCE, "src2", 32'h0);
        rd(probe_capture_pkg::IDX_PROBE1_INT_TRIG_SEL, "sel1", 32'h0);
        rd(probe_capture_pkg::IDX_PROBE2_INT_TRIG_SEL, "sel2", 32'h0);
        wr(probe_capture_pkg::IDX_PROBE_STATUS_WORD, 32'hFFFF);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0);
        xfer(1'b0, 18'h01000, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        xfer(1'b0, probe_capture_pkg::IDX_PROBE_STATUS_WORD, 32'h0, 2'h2);
        `CHK("misaligned err", 1'b1, rerr)
        xfer(1'b1, probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h0033, 2'h2);
        `CHK("misaligned wr err", 1'b1, rerr)
        rd(probe_capture_pkg::IDX_PROBE_FUNCTION, "function", 32'h0);
        $display("test reset_and_map done");
        // Probe one on its pin, continuous, both edges
        u_probe_trigger_source.set_pos(32'h1111, 32'h2222);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h0033);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0001);
        u_probe_trigger_source.set_pin(0, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0003);
        rd(probe_capture_pkg::IDX_PROBE1_POS_RISE, "p1 rise", 32'h1111);
        u_probe_trigger_source.set_pin(0, 1'b0);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0007);
        rd(probe_capture_pkg::IDX_PROBE1_POS_FALL, "p1 fall", 32'h1111);
        wr(probe_capture_pkg::IDX_PROBE1_LATCH_SOURCE, 32'h1);
        u_probe_trigger_source.set_pos(32'h3333, 32'h4444);
        u_probe_trigger_source.set_pin(0, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE1_POS_RISE, "p1 rise", 32'h4444);
        $display("test probe_one_pin done");
        // Sticky bits 0 and 1 set; only bit 0 unmasked
        wr(probe_capture_pkg::IDX_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(probe_capture_pkg::IDX_IRQ_STATUS, 32'h1);
        chk_irq(1'b0);
        rd(probe_capture_pkg::IDX_IRQ_STATUS, "irq status", 32'h2);
        $display("test interrupt done");
        // Timing output must latch the command position even with source 0
        u_probe_trigger_source.set_pin(0, 1'b0);
        wr(probe_capture_pkg::IDX_PROBE1_INT_TRIG_SEL, 32'h1);
        wr(probe_capture_pkg::IDX_PROBE1_LATCH_SOURCE, 32'h0);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h0037);
        u_probe_trigger_source.set_pos(32'h5555, 32'h6666);
        u_probe_trigger_source.set_pin(3, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE1_POS_RISE, "p1 rise", 32'h6666);
        // Probe two, zero-phase, first trigger only
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h1537);
        u_probe_trigger_source.set_pin(2, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0307);
        rd(probe_capture_pkg::IDX_PROBE2_POS_RISE, "p2 rise", 32'h5555);
        u_probe_trigger_source.set_pin(2, 1'b0);
        u_probe_trigger_source.set_pos(32'h7777, 32'h8888);
        u_probe_trigger_source.set_pin(2, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE2_POS_RISE, "p2 rise", 32'h5555);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h3537);
        u_probe_trigger_source.set_pin(2, 1'b0);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0707);
        rd(probe_capture_pkg::IDX_PROBE2_POS_FALL, "p2 fall", 32'h7777);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h3500);
        rd(probe_capture_pkg::IDX_PROBE_STATUS_WORD, "status", 32'h0700);
        $display("test internal_triggers done");
        // Probe two on its own pin latching command, then on the timing output
        wr(probe_capture_pkg::IDX_PROBE2_LATCH_SOURCE, 32'h1);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h3300);
        u_probe_trigger_source.set_pos(32'h9999, 32'hAAAA);
        u_probe_trigger_source.set_pin(1, 1'b1);
        rd(probe_capture_pkg::IDX_PROBE2_POS_RISE, "p2 rise", 32'hAAAA);
        wr(probe_capture_pkg::IDX_PROBE2_LATCH_SOURCE, 32'h0);
        wr(probe_capture_pkg::IDX_PROBE2_INT_TRIG_SEL, 32'h1);
        wr(probe_capture_pkg::IDX_PROBE_FUNCTION, 32'h3700);
        u_probe_trigger_source.set_pos(32'hBBBB, 32'hCCCC);
        u_probe_trigger_source.set_pin(3, 1'b0);
        rd(probe_capture_pkg::IDX_PROBE2_POS_FALL, "p2 fall", 32'hCCCC);
        $display("test probe_two_sources done");
        print_verdict();
    end
endmodule : touch_probe_latch_status_tb
